//--- design/pef_pkg.sv
// Constants shared by the event flag and interrupt mask block
package pef_pkg;

    localparam int          PEF_ADDR_W     = 12;
    localparam int          PEF_DATA_W     = 32;

    // Register byte offsets
    localparam logic [11:0] PEF_MASK2_OFF  = 12'h000;
    localparam logic [11:0] PEF_FLAG1_OFF  = 12'h004;
    localparam logic [11:0] PEF_FLAG2_OFF  = 12'h008;
    localparam logic [11:0] PEF_TRANS_OFF  = 12'h00C;

    // Second mask register bit positions
    localparam int          PEF_M_BOOST_OV    = 19;
    localparam int          PEF_M_BIAS_UVH    = 18;
    localparam int          PEF_M_COMM        = 17;
    localparam int          PEF_M_PREREG_FBOV = 16;
    localparam int          PEF_M_BOOST_UVH   = 15;
    localparam int          PEF_M_SUPPLY_UV7  = 14;
    localparam int          PEF_M_PREREG_UVH  = 12;
    localparam int          PEF_M_SUPPLY_UVL  = 11;
    localparam int          PEF_M_SUPPLY_UVH  = 10;
    localparam int          PEF_M_WAKE_A      = 9;
    localparam int          PEF_M_WAKE_B      = 8;

    // First flag register bit positions
    localparam int          PEF_F1_BIAS_UVH   = 23;
    localparam int          PEF_F1_BOOST_UVH  = 22;
    localparam int          PEF_F1_OC_LSB     = 16;
    localparam int          PEF_F1_CLK_OK     = 15;
    localparam int          PEF_F1_BOOST_OV   = 14;
    localparam int          PEF_F1_OT_LSB     = 8;

    // Second flag register bit positions
    localparam int          PEF_F2_PREREG_FBOV = 23;
    localparam int          PEF_F2_SUPPLY_UV7  = 22;
    localparam int          PEF_F2_ON_LSB      = 16;
    localparam int          PEF_F2_PREREG_UVL  = 15;
    localparam int          PEF_F2_PREREG_UVH  = 14;
    localparam int          PEF_F2_SUPPLY_UVL  = 13;
    localparam int          PEF_F2_SUPPLY_UVH  = 12;
    localparam int          PEF_F2_WAKE_B_LVL  = 11;
    localparam int          PEF_F2_WAKE_A_LVL  = 10;
    localparam int          PEF_F2_WAKE_B_SRC  = 9;
    localparam int          PEF_F2_WAKE_A_SRC  = 8;

    // Values after reset of the stored bits
    localparam logic [31:0] PEF_MASK2_RST  = 32'h0000_0000;
    localparam logic [31:0] PEF_FLAG1_RST  = 32'h00C0_0000;
    localparam logic [31:0] PEF_FLAG2_RST  = 32'h0040_F100;
    localparam logic [31:0] PEF_TRANS_RST  = 32'h0000_0000;
    // Clock edges after reset before pin edges count
    localparam logic [1:0]  PEF_ARM_CYC    = 2'h3;

    // Writable and clearable bit sets
    localparam logic [31:0] PEF_MASK2_WMASK = 32'h000F_DF00;
    localparam logic [31:0] PEF_FLAG1_CMASK = 32'h00FF_7F00;
    localparam logic [31:0] PEF_FLAG2_CMASK = 32'h00C0_F300;
    localparam logic [31:0] PEF_TRANS_CMASK = 32'h000E_0300;

    // Bus phase tracker, Gray coded along idle, setup, access
    typedef enum logic [1:0] {
        PEF_IDLE   = 2'b00,
        PEF_SETUP  = 2'b01,
        PEF_ACCESS = 2'b11
    } pef_phase_t;

endpackage : pef_pkg

//--- design/pef_event_flags.sv
// Event flags, live regulator state and interrupt masks behind an APB slave
`timescale 1ns/1ps

module pef_event_flags #(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        bias_uv_high_det,
    input  wire logic        boost_uv_high_det,
    input  wire logic        boost_ov_det,
    input  wire logic [5:0]  overcurrent_det,
    input  wire logic [5:0]  overtemp_det,
    input  wire logic        prereg_fb_ov_det,
    input  wire logic        supply_uv7_det,
    input  wire logic        prereg_uv_low_det,
    input  wire logic        prereg_uv_high_det,
    input  wire logic        supply_uv_low_det,
    input  wire logic        supply_uv_high_det,
    input  wire logic [5:0]  regulator_on,
    input  wire logic        ext_clock_div_in_range,
    input  wire logic        comm_error,
    input  wire logic        wake_pin_a,
    input  wire logic        wake_pin_b,
    input  wire logic        wake_by_pin_a,
    input  wire logic        wake_by_pin_b,
    output logic             irq
);

    localparam int SYNC_W = 31;

    // Byte-lane expansion of the strobes
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    // Bits a write-one-to-clear access removes from one register
    function automatic logic [31:0] w1c_bits(input logic        hit,
                                             input logic [31:0] data,
                                             input logic [31:0] strb_mask,
                                             input logic [31:0] cmask);
        w1c_bits = hit ? (data & strb_mask & cmask) : 32'h0000_0000;
    endfunction : w1c_bits

    // Register select decode
    function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] off);
        addr_is = (addr == off);
    endfunction : addr_is

    // Input synchronisers
    logic [SYNC_W-1:0] det_raw;
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_lvl;
    logic [SYNC_W-1:0] sync_prev;

    assign det_raw = {wake_pin_b, wake_pin_a, comm_error, ext_clock_div_in_range,
                      regulator_on, supply_uv_high_det, supply_uv_low_det,
                      prereg_uv_high_det, prereg_uv_low_det, supply_uv7_det,
                      prereg_fb_ov_det, overtemp_det, boost_ov_det, overcurrent_det,
                      boost_uv_high_det, bias_uv_high_det};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_meta <= '0;
            sync_lvl  <= '0;
        end else begin
            sync_meta <= det_raw;
            sync_lvl  <= sync_meta;
        end
    end

    // Previous level; edges held off until synchronisers carry real pin levels
    logic [1:0] edge_arm;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_prev <= '0;
            edge_arm  <= 2'h0;
        end else begin
            sync_prev <= sync_lvl;
            edge_arm  <= (edge_arm == pef_pkg::PEF_ARM_CYC) ? edge_arm : edge_arm + 2'h1;
        end
    end

    logic [SYNC_W-1:0] rise;
    logic [SYNC_W-1:0] toggle;
    assign rise   = (edge_arm == pef_pkg::PEF_ARM_CYC) ? (sync_lvl & ~sync_prev) : '0;
    assign toggle = (edge_arm == pef_pkg::PEF_ARM_CYC) ? (sync_lvl ^ sync_prev) : '0;

    // Unpacked synchronised levels and edges
    logic       s_bias_uvh_rise;
    logic       s_boost_uvh_rise;
    logic [5:0] s_oc_rise;
    logic       s_boost_ov_rise;
    logic [5:0] s_ot_rise;
    logic       s_fbov_rise;
    logic       s_uv7_rise;
    logic       s_pre_uvl_rise;
    logic       s_pre_uvh_rise;
    logic       s_sup_uvl_rise;
    logic       s_sup_uvh_rise;
    logic [5:0] s_reg_on;
    logic       s_clk_ok;
    logic       s_wake_a;
    logic       s_wake_b;
    logic       s_bias_uvh_tgl;
    logic       s_boost_ov_tgl;
    logic       s_comm_tgl;
    logic       s_wake_a_tgl;
    logic       s_wake_b_tgl;

    assign s_bias_uvh_rise  = rise[0];
    assign s_boost_uvh_rise = rise[1];
    assign s_oc_rise        = rise[7:2];
    assign s_boost_ov_rise  = rise[8];
    assign s_ot_rise        = rise[14:9];
    assign s_fbov_rise      = rise[15];
    assign s_uv7_rise       = rise[16];
    assign s_pre_uvl_rise   = rise[17];
    assign s_pre_uvh_rise   = rise[18];
    assign s_sup_uvl_rise   = rise[19];
    assign s_sup_uvh_rise   = rise[20];
    assign s_reg_on         = sync_lvl[26:21];
    assign s_clk_ok         = sync_lvl[27];
    assign s_wake_a         = sync_lvl[29];
    assign s_wake_b         = sync_lvl[30];
    assign s_bias_uvh_tgl   = toggle[0];
    assign s_boost_ov_tgl   = toggle[8];
    assign s_comm_tgl       = toggle[28];
    assign s_wake_a_tgl     = toggle[29];
    assign s_wake_b_tgl     = toggle[30];

    // APB slave: zero wait states, read data captured in setup phase
    pef_pkg::pef_phase_t phase;
    pef_pkg::pef_phase_t next_phase;

    always_comb begin
        case (phase)
            pef_pkg::PEF_IDLE:   next_phase = psel ? pef_pkg::PEF_SETUP : pef_pkg::PEF_IDLE;
            pef_pkg::PEF_SETUP:  next_phase = pef_pkg::PEF_ACCESS;
            pef_pkg::PEF_ACCESS: next_phase = psel ? pef_pkg::PEF_SETUP : pef_pkg::PEF_IDLE;
            default:             next_phase = pef_pkg::PEF_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= pef_pkg::PEF_IDLE;
        end else if (!(psel && penable)) begin
            phase <= psel ? pef_pkg::PEF_SETUP : pef_pkg::PEF_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    logic sel_mask2;
    logic sel_flag1;
    logic sel_flag2;
    logic sel_trans;
    logic mapped;
    logic wr_access;

    assign sel_mask2 = addr_is(paddr, pef_pkg::PEF_MASK2_OFF);
    assign sel_flag1 = addr_is(paddr, pef_pkg::PEF_FLAG1_OFF);
    assign sel_flag2 = addr_is(paddr, pef_pkg::PEF_FLAG2_OFF);
    assign sel_trans = addr_is(paddr, pef_pkg::PEF_TRANS_OFF);
    assign mapped    = sel_mask2 | sel_flag1 | sel_flag2 | sel_trans;
    assign wr_access = psel & penable & pwrite & mapped & (phase == pef_pkg::PEF_SETUP);

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    logic [31:0] wr_lanes;
    assign wr_lanes = lane_mask(pstrb);

    // Second interrupt mask register
    logic [31:0] interrupt_mask_second;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_mask_second <= pef_pkg::PEF_MASK2_RST;
        end else if (wr_access && sel_mask2) begin
            interrupt_mask_second <= (interrupt_mask_second & ~(wr_lanes & pef_pkg::PEF_MASK2_WMASK))
                                   | (pwdata & wr_lanes & pef_pkg::PEF_MASK2_WMASK);
        end
    end

    // Sticky flags: a set in the same cycle as a clear wins
    logic [31:0] flag1_store;
    logic [31:0] flag2_store;
    logic [31:0] trans_store;
    logic [31:0] flag1_set;
    logic [31:0] flag2_set;
    logic [31:0] trans_set;
    logic [31:0] flag1_clr;
    logic [31:0] flag2_clr;
    logic [31:0] trans_clr;

    assign flag1_set = {8'h00,
                        s_bias_uvh_rise,
                        s_boost_uvh_rise,
                        s_oc_rise,
                        1'b0,
                        s_boost_ov_rise,
                        s_ot_rise,
                        8'h00};

    assign flag2_set = {8'h00,
                        s_fbov_rise,
                        s_uv7_rise,
                        6'h00,
                        s_pre_uvl_rise,
                        s_pre_uvh_rise,
                        s_sup_uvl_rise,
                        s_sup_uvh_rise,
                        2'b00,
                        wake_by_pin_b,
                        wake_by_pin_a,
                        8'h00};

    // Transition latches share the mask bit positions
    assign trans_set = {12'h000,
                        s_boost_ov_tgl,
                        s_bias_uvh_tgl,
                        s_comm_tgl,
                        7'h00,
                        s_wake_a_tgl,
                        s_wake_b_tgl,
                        8'h00};

    // Zero bits and live bits fall outside the clear masks
    assign flag1_clr = w1c_bits(wr_access & sel_flag1, pwdata, wr_lanes,
                                pef_pkg::PEF_FLAG1_CMASK);
    assign flag2_clr = w1c_bits(wr_access & sel_flag2, pwdata, wr_lanes,
                                pef_pkg::PEF_FLAG2_CMASK);
    assign trans_clr = w1c_bits(wr_access & sel_trans, pwdata, wr_lanes,
                                pef_pkg::PEF_TRANS_CMASK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag1_store <= pef_pkg::PEF_FLAG1_RST;
        end else begin
            flag1_store <= (flag1_store & ~flag1_clr) | flag1_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag2_store <= pef_pkg::PEF_FLAG2_RST;
        end else begin
            flag2_store <= (flag2_store & ~flag2_clr) | flag2_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trans_store <= pef_pkg::PEF_TRANS_RST;
        end else begin
            trans_store <= (trans_store & ~trans_clr) | trans_set;
        end
    end

    // Read view: stored flags merged with live status
    logic [31:0] event_flags_first;
    logic [31:0] event_flags_second;
    logic [31:0] live1;
    logic [31:0] live2;
    assign live1 = {16'h0000, s_clk_ok, 15'h0000};
    assign live2 = {10'h000, s_reg_on, 4'h0, s_wake_b, s_wake_a, 10'h000};
    assign event_flags_first  = flag1_store | live1;
    assign event_flags_second = flag2_store | live2;

    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (sel_mask2) begin
            next_prdata = interrupt_mask_second;
        end else if (sel_flag1) begin
            next_prdata = event_flags_first;
        end else if (sel_flag2) begin
            next_prdata = event_flags_second;
        end else if (sel_trans) begin
            next_prdata = trans_store;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // Interrupt request
    logic [31:0] m;
    logic        irq_any;
    assign m = interrupt_mask_second;

    always_comb begin
        irq_any = 1'b0;
        irq_any = irq_any | (trans_store[pef_pkg::PEF_M_BOOST_OV] & ~m[pef_pkg::PEF_M_BOOST_OV]);
        irq_any = irq_any | (flag1_store[pef_pkg::PEF_F1_BOOST_OV] & ~m[pef_pkg::PEF_M_BOOST_OV]);
        irq_any = irq_any | (flag1_store[pef_pkg::PEF_F1_BOOST_UVH] & ~m[pef_pkg::PEF_M_BOOST_UVH]);
        irq_any = irq_any | (trans_store[pef_pkg::PEF_M_BIAS_UVH] & ~m[pef_pkg::PEF_M_BIAS_UVH]);
        irq_any = irq_any | (trans_store[pef_pkg::PEF_M_COMM] & ~m[pef_pkg::PEF_M_COMM]);
        irq_any = irq_any | (flag2_store[pef_pkg::PEF_F2_PREREG_FBOV]
                             & ~m[pef_pkg::PEF_M_PREREG_FBOV]);
        irq_any = irq_any | (flag2_store[pef_pkg::PEF_F2_SUPPLY_UV7]
                             & ~m[pef_pkg::PEF_M_SUPPLY_UV7]);
        irq_any = irq_any | (flag2_store[pef_pkg::PEF_F2_SUPPLY_UVL]
                             & ~m[pef_pkg::PEF_M_SUPPLY_UVL]);
        irq_any = irq_any | (flag2_store[pef_pkg::PEF_F2_PREREG_UVH]
                             & ~m[pef_pkg::PEF_M_PREREG_UVH]);
        irq_any = irq_any | (flag2_store[pef_pkg::PEF_F2_SUPPLY_UVH]
                             & ~m[pef_pkg::PEF_M_SUPPLY_UVH]);
        irq_any = irq_any | (trans_store[pef_pkg::PEF_M_WAKE_A] & ~m[pef_pkg::PEF_M_WAKE_A]);
        irq_any = irq_any | (trans_store[pef_pkg::PEF_M_WAKE_B] & ~m[pef_pkg::PEF_M_WAKE_B]);
        // Sources without a mask in this register
        irq_any = irq_any | flag2_store[pef_pkg::PEF_F2_PREREG_UVL];
        irq_any = irq_any | (|flag1_store[pef_pkg::PEF_F1_OC_LSB +: 6]);
        irq_any = irq_any | (|flag1_store[pef_pkg::PEF_F1_OT_LSB +: 6]);
        irq_any = irq_any | flag1_store[pef_pkg::PEF_F1_BIAS_UVH];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_any;
        end
    end

endmodule : pef_event_flags

//--- dv/pef_event_flags_assertions.sv
// Checker on the ports of the event flag block
`timescale 1ns/1ps

module pef_event_flags_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        bias_uv_high_det,
    input wire logic [5:0]  overcurrent_det,
    input wire logic [5:0]  overtemp_det,
    input wire logic [5:0]  regulator_on,
    input wire logic        ext_clock_div_in_range,
    input wire logic        wake_pin_a,
    input wire logic        wake_pin_b
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [8:0] live;
    logic [8:0] live_q;
    logic [2:0] age;
    logic       rd_setup;
    logic       wr_acc;

    assign live     = {regulator_on, ext_clock_div_in_range, wake_pin_b, wake_pin_a};
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_acc   = psel && penable && pwrite;

    // Cycles since a live input last moved
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_q <= 9'h000;
            age    <= 3'h0;
        end else begin
            live_q <= live;
            age    <= (live != live_q) ? 3'h0 : ((age == 3'h7) ? age : age + 3'h1);
        end
    end

    AST_MASK_RSV: assert property (rd_setup && paddr == 12'h000 |=> (prdata & 32'hFFF0_20FF) == 32'h0)
        else $error("mask register shows a reserved bit");
    AST_BAD_ERR: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h00C))
        else $error("error response does not match the address");
    AST_BAD_RDATA: assert property (rd_setup && paddr > 12'h00C |=> prdata == 32'h0)
        else $error("unmapped read returned data");
    AST_ON_LIVE: assert property (rd_setup && paddr == 12'h008 && age >= 3'h4 |=> prdata[21:16] == $past(regulator_on))
        else $error("regulator state bits differ from the inputs");
    AST_WAKE_LIVE: assert property (rd_setup && paddr == 12'h008 && age >= 3'h4 |=> prdata[11:10] == $past(live[1:0]))
        else $error("wake level bits differ from the pins");
    AST_CLK_LIVE: assert property (rd_setup && paddr == 12'h004 && age >= 3'h4 |=> prdata[15] == $past(ext_clock_div_in_range))
        else $error("clock window bit differs from the input");
    AST_BIAS_IRQ: assert property ($rose(bias_uv_high_det) |-> ##[2:5] irq)
        else $error("bias undervoltage raised no interrupt");
    AST_OT_IRQ: assert property ($rose(|overtemp_det) |-> ##[2:5] irq)
        else $error("overtemperature raised no interrupt");
    AST_OC_IRQ: assert property ($rose(|overcurrent_det) |-> ##[2:5] irq)
        else $error("overcurrent raised no interrupt");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_acc, 1) || $past(wr_acc, 2))
        else $error("interrupt fell without a register write");
endmodule : pef_event_flags_assertions

//--- dv/pef_apb_host.sv
// Host model issuing register transfers to the event flag block
`timescale 1ns/1ps

module pef_apb_host (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end

    // One transfer; released address and data lines are inverted, not held
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer
endmodule : pef_apb_host

//--- dv/pef_event_flags_bench.sv
// Self-checking bench for the event flag and interrupt mask block
`timescale 1ns/1ps

module pef_event_flags_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic [23:0] det;
    logic [5:0]  regulator_on;
    logic        ext_ok;
    logic        wake_by_a;
    logic        wake_by_b;
    int          n_fail = 0;
    int          compares = 0;

    pef_apb_host pef_apb_host_inst (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    pef_event_flags pef_event_flags_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .bias_uv_high_det(det[0]),
        .boost_uv_high_det(det[1]), .boost_ov_det(det[2]), .prereg_fb_ov_det(det[3]),
        .supply_uv7_det(det[4]), .prereg_uv_low_det(det[5]), .prereg_uv_high_det(det[6]),
        .supply_uv_low_det(det[7]), .supply_uv_high_det(det[8]), .comm_error(det[9]),
        .wake_pin_a(det[10]), .wake_pin_b(det[11]), .overcurrent_det(det[17:12]),
        .overtemp_det(det[23:18]), .regulator_on(regulator_on),
        .ext_clock_div_in_range(ext_ok), .wake_by_pin_a(wake_by_a),
        .wake_by_pin_b(wake_by_b), .irq(irq));

    always #20 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        pef_apb_host_inst.xfer(1'h1, a, d, q, e);
        check({31'h0, e}, 32'h0);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        pef_apb_host_inst.xfer(1'h0, a, 32'h0, q, e);
        check({31'h0, e}, 32'h0);
    endtask : rd

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        rd(a, q);
        check(q, exp);
    endtask : rd_chk

    task automatic clear_all;
        wr(12'h004, 32'hFFFF_FFFF);
        wr(12'h008, 32'hFFFF_FFFF);
        wr(12'h00C, 32'hFFFF_FFFF);
    endtask : clear_all

    task automatic t_start;
        rd_chk(12'h000, 32'h0);
        rd_chk(12'h004, 32'h00C0_8000);
        rd_chk(12'h008, 32'h007F_F500);
        clear_all;
        rd_chk(12'h004, 32'h0000_8000);
        rd_chk(12'h008, 32'h003F_0400);
        check({31'h0, irq}, 32'h0);
        wr(12'h000, 32'hFFFF_FFFF);
        rd_chk(12'h000, 32'h000F_DF00);
        wr(12'h000, 32'h0);
    endtask : t_start

    // Toggle one detector, judge flag and interrupt with and without its mask
    task automatic t_event(input int i, input logic [11:0] a, input int b, input int m);
        logic [31:0] q;
        if (m >= 0) wr(12'h000, 32'h1 << m);
        det[i] <= ~det[i];
        repeat (6) @(posedge pclk);
        check({31'h0, irq}, {31'h0, m < 0});
        wr(a, 32'h0);
        rd(a, q);
        check((q >> b) & 32'h1, 32'h1);
        if (m >= 0) wr(12'h000, 32'h0);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        det[i] <= ~det[i];
        repeat (6) @(posedge pclk);
        clear_all;
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rd(a, q);
        check((q >> b) & 32'h1, 32'h0);
    endtask : t_event

    task automatic t_events;
        t_event(0, 12'h004, 23, -1);
        t_event(1, 12'h004, 22, 15);
        t_event(2, 12'h004, 14, 19);
        t_event(2, 12'h00C, 19, 19);
        t_event(3, 12'h008, 23, 16);
        t_event(4, 12'h008, 22, 14);
        t_event(5, 12'h008, 15, -1);
        t_event(6, 12'h008, 14, 12);
        t_event(7, 12'h008, 13, 11);
        t_event(8, 12'h008, 12, 10);
        t_event(9, 12'h00C, 17, 17);
        t_event(10, 12'h00C, 9, 9);
        t_event(11, 12'h00C, 8, 8);
        for (int k = 0; k < 6; k++) begin
            t_event(12 + k, 12'h004, 16 + k, -1);
            t_event(18 + k, 12'h004, 8 + k, -1);
        end
    endtask : t_events

    task automatic t_live;
        logic [31:0] q;
        logic        e;
        regulator_on <= 6'h15;
        ext_ok       <= 1'h0;
        det[11]      <= 1'h1;
        repeat (6) @(posedge pclk);
        rd_chk(12'h004, 32'h0);
        wr(12'h008, 32'h003F_0C00);
        rd_chk(12'h008, 32'h0015_0C00);
        regulator_on <= 6'h3F;
        ext_ok       <= 1'h1;
        det[11]      <= 1'h0;
        wake_by_b    <= 1'h1;
        @(posedge pclk);
        wake_by_b <= 1'h0;
        wake_by_a <= 1'h1;
        @(posedge pclk);
        wake_by_a <= 1'h0;
        repeat (6) @(posedge pclk);
        clear_all;
        pef_apb_host_inst.xfer(1'h0, 12'h010, 32'h0, q, e);
        check(q, 32'h0);
        check({31'h0, e}, 32'h1);
        pef_apb_host_inst.xfer(1'h1, 12'h010, 32'hFFFF_FFFF, q, e);
        check({31'h0, e}, 32'h1);
        rd_chk(12'h000, 32'h0);
    endtask : t_live

    task automatic t_wake;
        wake_by_b <= 1'h1;
        @(posedge pclk);
        wake_by_b <= 1'h0;
        wake_by_a <= 1'h1;
        @(posedge pclk);
        wake_by_a <= 1'h0;
        rd_chk(12'h008, 32'h003F_0700);
        wr(12'h008, 32'h0000_0200);
        rd_chk(12'h008, 32'h003F_0500);
        wr(12'h008, 32'h0000_0100);
        rd_chk(12'h008, 32'h003F_0400);
    endtask : t_wake

    task automatic close_out;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        pclk         = 1'h0;
        presetn      = 1'h0;
        det          = 24'h000400;
        regulator_on = 6'h3F;
        ext_ok       = 1'h1;
        wake_by_a    = 1'h0;
        wake_by_b    = 1'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        t_start;
        t_events;
        t_live;
        t_wake;
        close_out;
    end

    initial begin
        #400000;
        n_fail++;
        close_out;
    end
endmodule : pef_event_flags_bench

bind pef_event_flags pef_event_flags_assertions pef_event_flags_assertions_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .bias_uv_high_det(bias_uv_high_det), .overcurrent_det(overcurrent_det),
    .overtemp_det(overtemp_det), .regulator_on(regulator_on),
    .ext_clock_div_in_range(ext_clock_div_in_range), .wake_pin_a(wake_pin_a),
    .wake_pin_b(wake_pin_b));
